// *** src/sas_defines.svh ***
// Purpose: Constants for the successive-approximation converter sequencer
// Assumes: One 100 MHz clock; conversion steps counted in clock cycles
// Notes: Timing counts derived from the printed figures
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_DATA_W 8
`define SAS_LADDER_STEPS 256
`define SAS_CHAN_W 2
`define SAS_RESULT_RST 8'h00
`define SAS_MSB_CODE 8'h80
// Clock period and the settling time of one trial step
`define SAS_CLK_PERIOD_NS 10
`define SAS_TRIAL_NS 50
`define SAS_TRIAL_CYC ((`SAS_TRIAL_NS + `SAS_CLK_PERIOD_NS - 1) / `SAS_CLK_PERIOD_NS)
// Upper bound on a whole conversion, in machine cycles
`define SAS_MAX_MACH_CYC 50

`endif

// *** src/sas_pkg.sv ***
// Purpose: Types for the converter sequencer
// Assumes: Included constants header
// Notes: State is one packed struct, except the busy flag, which the sequencer keeps in its own register
`include "sas_defines.svh"

package sas_pkg;

  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_TRIAL,
    SAS_DONE
  } sas_state_e;

  typedef struct packed {
    sas_state_e state;
    logic [`SAS_DATA_W-1:0] result;
    logic [2:0] bit_idx;
    logic [7:0] wait_cnt;
    logic done_flag;
    logic irq_flag;
    logic irq_pulse;
    logic [`SAS_CHAN_W-1:0] chan;
  } sas_regs_s;

endpackage : sas_pkg

// *** src/sas_sequencer.sv ***
// Purpose: Successive-approximation sequencer driving ladder code and channel select
// Assumes: Comparator output synchronous to i_clk; high means ladder below input
// Notes: Software controls arrive as plain ports; results are plain outputs
`timescale 1ns/1ns

module sas_sequencer
  import sas_pkg::*;
#(
  parameter int unsigned TRIAL_CYC = `SAS_TRIAL_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`SAS_CHAN_W-1:0] i_chan_sel,
  input wire logic i_done_wr_zero,
  input wire logic i_irq_clr,
  input wire logic i_ladder_below_input,
  output logic [`SAS_DATA_W-1:0] o_ladder_code,
  output logic [`SAS_CHAN_W-1:0] o_chan_route,
  output logic [`SAS_DATA_W-1:0] o_result,
  output logic o_done_flag,
  output logic o_irq_flag,
  output logic o_irq_pulse,
  output logic o_busy
);

  // ********************************************
  // State
  // ********************************************
  sas_regs_s st_reg;
  sas_regs_s st_next;
  logic busy_reg;
  logic busy_next;

  localparam logic [7:0] TRIAL_LAST = 8'(TRIAL_CYC - 1);

  function automatic logic [`SAS_DATA_W-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = `SAS_DATA_W'(1) << idx;
  endfunction : bit_mask

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    st_next = st_reg;
    st_next.irq_pulse = 1'b0;
    busy_next = busy_reg;
    st_next.chan = i_chan_sel;
    // Clear of the request flag loses to a same-cycle set
    if (i_irq_clr) begin
      st_next.irq_flag = 1'b0;
    end
    case (st_reg.state)
      SAS_IDLE, SAS_DONE: begin
        if (i_done_wr_zero) begin
          // Request flag deliberately left as is
          st_next.result = `SAS_RESULT_RST | `SAS_MSB_CODE;
          st_next.bit_idx = 3'h7;
          st_next.wait_cnt = 8'h00;
          st_next.done_flag = 1'b0;
          st_next.state = SAS_TRIAL;
          busy_next = 1'b1;
        end
      end
      SAS_TRIAL: begin
        // Each step holds the code steady for the ladder to settle
        if (st_reg.wait_cnt == TRIAL_LAST) begin
          st_next.wait_cnt = 8'h00;
          if (!i_ladder_below_input) begin
            st_next.result = st_reg.result & ~bit_mask(st_reg.bit_idx);
          end
          if (st_reg.bit_idx == 3'h0) begin
            st_next.state = SAS_DONE;
            st_next.done_flag = 1'b1;
            st_next.irq_flag = 1'b1;
            st_next.irq_pulse = 1'b1;
            busy_next = 1'b0;
          end else begin
            st_next.bit_idx = st_reg.bit_idx - 3'h1;
            st_next.result = (st_reg.result & ~(i_ladder_below_input ? 8'h00 : bit_mask(st_reg.bit_idx)))
              | bit_mask(st_reg.bit_idx - 3'h1);
          end
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt + 8'h01;
        end
      end
      default: begin
        st_next.state = SAS_IDLE;
      end
    endcase
  end

  // ********************************************
  // Registers
  // ********************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{state: SAS_IDLE, result: `SAS_RESULT_RST, bit_idx: 3'h7, wait_cnt: 8'h00,
                  done_flag: 1'b1, irq_flag: 1'b0, irq_pulse: 1'b0, chan: 2'h0};
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      busy_reg <= busy_next;
    end
  end

  assign o_ladder_code = st_reg.result;
  assign o_chan_route = st_reg.chan;
  assign o_result = st_reg.result; // Intermediate while busy
  assign o_done_flag = st_reg.done_flag;
  assign o_irq_flag = st_reg.irq_flag;
  assign o_irq_pulse = st_reg.irq_pulse;
  assign o_busy = busy_reg;

endmodule : sas_sequencer

// *** verif/sas_analog_model.sv ***
// Purpose: Ladder, input selector and comparator model
// Assumes: Voltages in half-step units of the supply
// Notes: Answers at once
`timescale 1ns/1ns
module sas_analog_model (
  input wire logic [7:0] i_code,
  input wire logic [1:0] i_chan,
  input wire logic [35:0] i_vin_x2,
  output logic o_below
);
  // Ladder taken as always connected to the supply
  logic [8:0] lad;
  assign lad = (i_code == 8'h00) ? 9'h000 : {i_code, 1'b0} - 9'h001;
  assign o_below = lad < i_vin_x2[i_chan*9 +: 9];
endmodule : sas_analog_model

// *** verif/sas_sequencer_asserts.sv ***
// Purpose: Sequencer port checks
// Assumes: Bound to every sas_sequencer instance
// Notes: Done may land one cycle late
`timescale 1ns/1ns
module sas_sequencer_asserts #(parameter int unsigned TRIAL_CYC = 5) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_chan_sel,
  input wire logic i_done_wr_zero,
  input wire logic i_irq_clr,
  input wire logic [1:0] o_chan_route,
  input wire logic [7:0] o_result,
  input wire logic o_done_flag,
  input wire logic o_irq_flag,
  input wire logic o_irq_pulse,
  input wire logic o_busy
);
  localparam int C = 8 * TRIAL_CYC;
  localparam int C1 = C + 1;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  start_trial_a: assert property (i_done_wr_zero && !o_busy |=> o_busy && o_result == 8'h80)
    else $error("start");
  done_low_a: assert property (o_busy |-> !o_done_flag) else $error("done");
  finish_time_a: assert property (i_done_wr_zero && !o_busy |-> ##[C:C1] o_irq_pulse)
    else $error("late");
  pulse_once_a: assert property (o_irq_pulse |=> !o_irq_pulse) else $error("pulse");
  pulse_flag_a: assert property ($rose(o_done_flag) |-> o_irq_pulse && o_irq_flag) else $error("flag");
  irq_keep_a: assert property (i_done_wr_zero && o_irq_flag && !i_irq_clr |=> o_irq_flag)
    else $error("keep");
  irq_clear_a: assert property (i_irq_clr && !o_busy |=> !o_irq_flag) else $error("clear");
  chan_route_a: assert property (o_chan_route == $past(i_chan_sel)) else $error("route");
endmodule : sas_sequencer_asserts
bind sas_sequencer sas_sequencer_asserts #(.TRIAL_CYC(TRIAL_CYC)) u_chk (.*);

// *** verif/sas_sequencer_tb.sv ***
// Purpose: Self-checking sequencer bench
// Assumes: One-cycle trials
// Notes: Inputs in half steps
`timescale 1ns/1ns
module sas_sequencer_tb;
  logic i_clk = 0, i_rst_n = 0, i_done_wr_zero = 0, i_irq_clr = 0, i_ladder_below_input;
  logic [1:0] i_chan_sel = 0, o_chan_route;
  logic [35:0] analog_input_voltage = 0;
  logic o_done_flag, o_irq_flag, o_irq_pulse, o_busy;
  logic [7:0] o_ladder_code, o_result;
  int errors = 0, tests_run = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  sas_sequencer #(.TRIAL_CYC(1)) u_sas_sequencer (.*);
  sas_analog_model u_sas_analog_model (.i_code(o_ladder_code), .i_chan(o_chan_route), .i_vin_x2(analog_input_voltage),
    .o_below(i_ladder_below_input));
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask : pulse
  task automatic conv(input logic [1:0] c, input logic [8:0] v);
    int k;
    i_chan_sel = c;
    analog_input_voltage[c*9 +: 9] = v;
    step(2);
    pulse(i_done_wr_zero);
    chk("first", o_result, 8'h80);
    chk("busy", {o_busy, o_done_flag}, 8'h02);
    chk("code", o_ladder_code, 8'h80);
    // Result is read once done is seen, or after 50 cycles without it
    for (k = 0; k < 50 && o_done_flag !== 1'b1; k++) step(1);
    // The completion pulse stands for the taken interrupt
    chk("flags", {o_done_flag, o_irq_flag, o_irq_pulse}, 8'h07);
    chk("result", o_result, v > 9'h1FD ? 8'hFF : v[8:1]);
    chk("route", o_chan_route, c);
    $display("conversion test done");
  endtask : conv
  task automatic t_irq;
    pulse(i_done_wr_zero);
    chk("keep", o_irq_flag, 8'h01);
    pulse(i_irq_clr);
    chk("clear", o_irq_flag, 8'h00);
    step(12);
    chk("again", {o_done_flag, o_irq_flag}, 8'h03);
    $display("irq test done");
  endtask : t_irq
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    step(2);
    chk("rst_flags", {o_done_flag, o_irq_flag, o_irq_pulse, o_busy}, 8'h08);
    chk("rst_result", o_result, 8'h00);
    i_rst_n = 1;
    conv(2'h0, 9'h000);
    conv(2'h1, 9'h1FF);
    conv(2'h2, 9'h101);
    conv(2'h3, 9'h0AB);
    $display("channel test done");
    t_irq();
    end_of_test();
  end
endmodule : sas_sequencer_tb
